/* hdl/iosc_consts.svh */
// iosc_consts.svh: offsets, field positions, reset values, select and config codes, divider and multiplier factors
// assumes inclusion by the design files and by the testbench
`ifndef IOSC_CONSTS_SVH
`define IOSC_CONSTS_SVH
`define IOSC_OFF_TUNING       8'h00
`define IOSC_OFF_CONTROL      8'h04
`define IOSC_OFF_CONFIG       8'h08
`define IOSC_OFF_STATUS       8'h0c
`define IOSC_TUN_SRC_BIT      7
`define IOSC_TUN_MUL_BIT      6
`define IOSC_TUN_TRIM_MSB     5
`define IOSC_TRIM_RESET       6'h00
`define IOSC_TRIM_MAX         6'h1f
`define IOSC_TRIM_MIN         6'h20
`define IOSC_FSEL_RESET       3'h3
`define IOSC_FSEL_LOW         3'h0
`define IOSC_FSEL_8M          3'h6
`define IOSC_FSEL_16M         3'h7
`define IOSC_CFG_RESET        4'h9
`define IOSC_CFG_INT_A        4'h8
`define IOSC_CFG_INT_B        4'h9
`define IOSC_CFG_XTAL_MUL     4'h6
`define IOSC_HF_DIV_LOW       512
`define IOSC_MUL_FACTOR       3'h4
`endif

/* hdl/iosc_ctrl.sv */
// iosc_ctrl.sv: internal oscillator tuning, frequency select and multiplier gating
// assumes an axi4-lite master on aclk and configuration levels from the same domain
//
// Overview of operation
// - trim is a six-bit two's complement field, zero after reset.
// - trim 011111 fastest, 100000 slowest, zero is the calibrated frequency.
// - a trim write starts the shift at once; no completion flag exists.
// - trim never alters the low-frequency oscillator or its dependent timers.
// - source bit 7 set takes 16 MHz divided by 512, clear takes 31 kHz.
// - multiplier bit 6 enables the multiplier only at 8 or 16 MHz.
// - multiplier bit acts only in internal modes at 8/16 MHz, else reads zero.
// - low oscillator on for select 000 with source clear, or timer users.
// - the 31 kHz oscillator clocks power-up timer, watchdog and fail-safe monitor.
// - three-bit select picks one of eight internal frequencies.
// - frequency select resets to 011, the 1 MHz output.
// - an enabled internal multiplier multiplies by four, up to 64 MHz.
// - internal multiplier runs only for config 1000/1001 and select 110/111.
// - crystal multiplier mode multiplies by four, ignoring the software bit.
// - crystal multiplier exists only with configuration code 0110.
// - high oscillator runs for internal clock except select 000 with source bit clear, and for config 1000/1001.
`timescale 1ns/1ns
`default_nettype none
`include "iosc_consts.svh"
module iosc_ctrl
  import iosc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  power_up_timer,
  input  wire logic                  watchdog_en,
  input  wire logic                  fail_safe_monitor,
  output var  iosc_pkg::iosc_osc_ctl_t osc_ctl,
  output var  logic [2:0]            clk_mult,
  output var  logic [9:0]            postscale_div
);
  import iosc_pkg::*;

  localparam logic [9:0] HF_DIV_LOW = 10'(`IOSC_HF_DIV_LOW);

  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  iosc_tuning_t tuning_q;
  logic [2:0]   fsel_q;
  iosc_src_t    src_q;
  logic [3:0]   cfg_q;

  logic mul_avail;
  logic mul_active;
  logic xtal_mul_active;
  logic lf_osc_en;
  logic hf_osc_en;
  logic wr_fire;

  // divider from 16 MHz for each select code but 000 with source bit clear, which gives 0 for the 31 kHz path
  function automatic logic [9:0] div_of(input logic [2:0] sel, input logic hf_low);
    logic [9:0] d;
    d = 10'h001;
    unique case (sel)
      3'h7: d = 10'h001;
      3'h6: d = 10'h002;
      3'h5: d = 10'h004;
      3'h4: d = 10'h008;
      3'h3: d = 10'h010;
      3'h2: d = 10'h020;
      3'h1: d = 10'h040;
      3'h0: d = hf_low ? HF_DIV_LOW : 10'h000;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    return st[0] ? wd[7:0] : old;
  endfunction

  function automatic logic [7:0] tuning_read(input iosc_tuning_t t, input logic avail);
    return {t.low_src_hf, t.mul_req & avail, t.trim};
  endfunction

  iosc_gate u_gate (
    .primary_osc_config     (cfg_q),
    .internal_freq_select   (fsel_q),
    .low_freq_source_select (tuning_q.low_src_hf),
    .multiplier_enable      (tuning_q.mul_req),
    .internal_clock_select  (src_q == IOSC_SRC_INTERNAL),
    .power_up_timer         (power_up_timer),
    .watchdog_en            (watchdog_en),
    .fail_safe_monitor      (fail_safe_monitor),
    .mul_avail              (mul_avail),
    .mul_active             (mul_active),
    .xtal_mul_active        (xtal_mul_active),
    .lf_osc_en              (lf_osc_en),
    .hf_osc_en              (hf_osc_en)
  );

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

  // address and data latched separately, so either order works
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      unique case (awaddr_q[7:2])
        6'(`IOSC_OFF_TUNING >> 2), 6'(`IOSC_OFF_CONTROL >> 2),
        6'(`IOSC_OFF_CONFIG >> 2), 6'(`IOSC_OFF_STATUS >> 2): bresp_q <= 2'b00;
        default: bresp_q <= 2'b10;
      endcase
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // trim goes straight to the oscillator; no settle indication by design
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tuning_q <= '{low_src_hf: 1'b0, mul_req: 1'b0, trim: `IOSC_TRIM_RESET};
    end else if (wr_fire && awaddr_q == `IOSC_OFF_TUNING && wstrb_q[0]) begin
      tuning_q <= iosc_tuning_t'(byte_merge(8'(tuning_q), wdata_q, wstrb_q));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fsel_q <= `IOSC_FSEL_RESET;
      src_q  <= IOSC_SRC_PRIMARY;
    end else if (wr_fire && awaddr_q == `IOSC_OFF_CONTROL && wstrb_q[0]) begin
      fsel_q <= wdata_q[6:4];
      src_q  <= wdata_q[1] ? IOSC_SRC_INTERNAL :
                (wdata_q[0] ? IOSC_SRC_SECONDARY : IOSC_SRC_PRIMARY);
    end
  end

  // configuration word stands in for the fuse bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `IOSC_CFG_RESET;
    end else if (wr_fire && awaddr_q == `IOSC_OFF_CONFIG && wstrb_q[0]) begin
      cfg_q <= wdata_q[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= 2'b00;
      unique case (s_axi_araddr[7:2])
        6'(`IOSC_OFF_TUNING >> 2):  rdata_q <= {24'h0, tuning_read(tuning_q, mul_avail)};
        6'(`IOSC_OFF_CONTROL >> 2): rdata_q <= {25'h0, fsel_q, 2'b00, 2'(src_q)};
        6'(`IOSC_OFF_CONFIG >> 2):  rdata_q <= {28'h0, cfg_q};
        6'(`IOSC_OFF_STATUS >> 2):  rdata_q <= {27'h0, hf_osc_en, lf_osc_en,
                                                mul_avail, mul_active, xtal_mul_active};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // outputs registered so analogue controls never see decode glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ctl       <= '0;
      clk_mult      <= 3'h1;
      postscale_div <= 10'h010;
    end else begin
      osc_ctl.hf_osc_en       <= hf_osc_en;
      osc_ctl.lf_osc_en       <= lf_osc_en;
      osc_ctl.mul_active      <= mul_active;
      osc_ctl.xtal_mul_active <= xtal_mul_active;
      osc_ctl.low_clk_from_hf <= (fsel_q == `IOSC_FSEL_LOW) && tuning_q.low_src_hf;
      osc_ctl.freq_sel        <= fsel_q;
      osc_ctl.hf_trim         <= tuning_q.trim;
      clk_mult      <= (mul_active || xtal_mul_active) ? `IOSC_MUL_FACTOR : 3'h1;
      postscale_div <= div_of(fsel_q, tuning_q.low_src_hf);
    end
  end
endmodule
`default_nettype wire

/* hdl/iosc_gate.sv */
// iosc_gate.sv: combinational enables for the internal oscillators and multiplier
// assumes settings come from registers on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "iosc_consts.svh"
module iosc_gate (
  input  wire logic [3:0] primary_osc_config,
  input  wire logic [2:0] internal_freq_select,
  input  wire logic       low_freq_source_select,
  input  wire logic       multiplier_enable,
  input  wire logic       internal_clock_select,
  input  wire logic       power_up_timer,
  input  wire logic       watchdog_en,
  input  wire logic       fail_safe_monitor,
  output var  logic       mul_avail,
  output var  logic       mul_active,
  output var  logic       xtal_mul_active,
  output var  logic       lf_osc_en,
  output var  logic       hf_osc_en
);
  logic cfg_int;
  logic fsel_fast;

  always_comb begin
    cfg_int = (primary_osc_config == `IOSC_CFG_INT_A) ||
              (primary_osc_config == `IOSC_CFG_INT_B);
    fsel_fast = (internal_freq_select == `IOSC_FSEL_8M) ||
                (internal_freq_select == `IOSC_FSEL_16M);
    mul_avail = cfg_int && fsel_fast;
    mul_active = mul_avail && multiplier_enable;
    xtal_mul_active = (primary_osc_config == `IOSC_CFG_XTAL_MUL);
    // lf path ignores trim entirely so timer timing stays fixed
    lf_osc_en = ((internal_freq_select == `IOSC_FSEL_LOW) && !low_freq_source_select) ||
                power_up_timer || watchdog_en || fail_safe_monitor;
    hf_osc_en = (internal_clock_select && (internal_freq_select != `IOSC_FSEL_LOW)) ||
                (internal_clock_select && (internal_freq_select == `IOSC_FSEL_LOW) &&
                 low_freq_source_select) || cfg_int;
  end
endmodule
`default_nettype wire

/* hdl/iosc_pkg.sv */
// iosc_pkg.sv: types shared by the oscillator control block
// assumes iosc_consts.svh for all numeric values
package iosc_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic        valid;
  } iosc_addr_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
    logic        valid;
  } iosc_wdata_t;

  typedef struct packed {
    logic       low_src_hf;
    logic       mul_req;
    logic [5:0] trim;
  } iosc_tuning_t;

  typedef struct packed {
    logic       hf_osc_en;
    logic       lf_osc_en;
    logic       mul_active;
    logic       xtal_mul_active;
    logic       low_clk_from_hf;
    logic [2:0] freq_sel;
    logic [5:0] hf_trim;
  } iosc_osc_ctl_t;

  typedef enum logic [1:0] {
    IOSC_SRC_PRIMARY,
    IOSC_SRC_SECONDARY,
    IOSC_SRC_INTERNAL
  } iosc_src_t;
endpackage

/* tb/iosc_ctrl_properties.sv */
// iosc_ctrl_properties.sv: port-level checks of the oscillator control block
// assumes a bind onto iosc_ctrl; one aclk domain, reset aresetn
`timescale 1ns/1ns
`default_nettype none
module iosc_ctrl_properties
  import iosc_pkg::*;
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    power_up_timer,
  input wire logic                    watchdog_en,
  input wire logic                    fail_safe_monitor,
  input wire iosc_pkg::iosc_osc_ctl_t osc_ctl,
  input wire logic [2:0]              clk_mult,
  input wire logic [9:0]              postscale_div
);
  logic ok_q;
  // outputs lag reset release by one edge, so skip that edge
  always_ff @(posedge aclk) ok_q <= aresetn;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ok_q);

  a_mul_at_fast: assert property (osc_ctl.mul_active |-> osc_ctl.freq_sel inside {3'h6, 3'h7})
    else $error("multiplier active at a slow select");
  a_mul_exclusive: assert property (osc_ctl.xtal_mul_active |-> !osc_ctl.mul_active)
    else $error("both multipliers active");
  a_mult_four: assert property ((osc_ctl.mul_active || osc_ctl.xtal_mul_active) |-> clk_mult == 3'h4)
    else $error("active multiplier not four");
  a_mult_one: assert property (!(osc_ctl.mul_active || osc_ctl.xtal_mul_active) |-> clk_mult == 3'h1)
    else $error("idle multiplier not one");
  a_div_halving: assert property (osc_ctl.freq_sel != 3'h0 |-> postscale_div == (10'h1 << (3'h7 - osc_ctl.freq_sel)))
    else $error("postscaler does not match select");
  a_div_from_hf: assert property (osc_ctl.freq_sel == 3'h0 && osc_ctl.low_clk_from_hf |-> postscale_div == 10'h200)
    else $error("low option from hf not divided by 512");
  a_div_from_lf: assert property (osc_ctl.freq_sel == 3'h0 && !osc_ctl.low_clk_from_hf |-> postscale_div == 10'h0 && osc_ctl.lf_osc_en)
    else $error("low option not taken from lf oscillator");
  a_lf_for_timers: assert property ($past(power_up_timer) || $past(watchdog_en) || $past(fail_safe_monitor) |-> osc_ctl.lf_osc_en)
    else $error("lf oscillator off while a timer needs it");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule
`default_nettype wire

/* tb/tb.sv */
// tb.sv: register-level tests of iosc_ctrl through axi4-lite
// assumes iosc_pkg, iosc_consts.svh and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "iosc_consts.svh"
module tb;
  import iosc_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [7:0]    s_axi_awaddr = 8'h00;
  logic [7:0]    s_axi_araddr = 8'h00;
  logic [31:0]   s_axi_wdata = 32'h0;
  logic [3:0]    s_axi_wstrb = 4'h0;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic          power_up_timer = 1'b0, watchdog_en = 1'b0, fail_safe_monitor = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [31:0]   s_axi_rdata;
  iosc_osc_ctl_t osc_ctl;
  logic [2:0]    clk_mult;
  logic [9:0]    postscale_div;
  logic [5:0]    trims [3] = '{6'h1f, 6'h20, 6'h01};
  int            num_errors = 0, checks_done = 0, cycles = 0;

  always #5 aclk = ~aclk;

  iosc_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_up_timer, .watchdog_en, .fail_safe_monitor,
    .osc_ctl, .clk_mult, .postscale_div);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
                    input logic [1:0] er = 2'b00);
    bit aw = 1'b0;
    bit w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b1;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    // osc_ctl follows the register one cycle later
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IOSC_OFF_TUNING, 32'h0);
    rd(`IOSC_OFF_CONTROL, 32'h30);
    rd(`IOSC_OFF_CONFIG, 32'h9);
    rd(`IOSC_OFF_STATUS, 32'h10);
    chk(postscale_div, 10'd16);
    for (int i = 0; i < 3; i++) begin
      wr(`IOSC_OFF_TUNING, {2'b00, trims[i]});
      chk(osc_ctl.hf_trim, trims[i]);
      chk(osc_ctl.lf_osc_en, 1'b0);
    end
    // software trims down on framing errors, then back up on data errors
    wr(`IOSC_OFF_TUNING, 8'h00);
    chk(osc_ctl.hf_trim, 6'h00);
    wr(`IOSC_OFF_TUNING, 8'h01);
    chk(osc_ctl.hf_trim, 6'h01);
    wr(`IOSC_OFF_TUNING, 8'h00, 4'h0);
    rd(`IOSC_OFF_TUNING, 32'h01);
    wr(`IOSC_OFF_TUNING, 8'h40);
    rd(`IOSC_OFF_TUNING, 32'h0);
    chk(clk_mult, 3'h1);
    for (int f = 1; f < 8; f++) begin
      wr(`IOSC_OFF_CONTROL, {1'b0, 3'(f), 4'h0});
      chk(postscale_div, 10'h1 << (7 - f));
      chk(clk_mult, (f >= 6) ? 3'h4 : 3'h1);
      rd(`IOSC_OFF_TUNING, (f >= 6) ? 32'h40 : 32'h0);
    end
    wr(`IOSC_OFF_CONFIG, {4'h0, `IOSC_CFG_INT_A});
    chk(clk_mult, 3'h4);
    wr(`IOSC_OFF_CONFIG, 8'h00);
    chk(clk_mult, 3'h1);
    rd(`IOSC_OFF_TUNING, 32'h0);
    wr(`IOSC_OFF_CONFIG, {4'h0, `IOSC_CFG_XTAL_MUL});
    chk(osc_ctl.xtal_mul_active, 1'b1);
    wr(`IOSC_OFF_TUNING, 8'h00);
    chk(clk_mult, 3'h4);
    wr(`IOSC_OFF_CONFIG, {4'h0, `IOSC_CFG_INT_B});
    wr(`IOSC_OFF_CONTROL, 8'h00);
    chk(postscale_div, 10'h0);
    chk(osc_ctl.lf_osc_en, 1'b1);
    wr(`IOSC_OFF_CONTROL, 8'h02);
    wr(`IOSC_OFF_TUNING, 8'h80);
    chk(postscale_div, 10'h200);
    chk(osc_ctl.lf_osc_en, 1'b0);
    chk(osc_ctl.hf_osc_en, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      {power_up_timer, watchdog_en, fail_safe_monitor} <= 3'b100 >> i;
      repeat (3) @(posedge aclk);
      chk(osc_ctl.lf_osc_en, 1'b1);
    end
    @(posedge aclk);
    fail_safe_monitor <= 1'b0;
    rd(`IOSC_OFF_CONTROL, 32'h02);
    wr(`IOSC_OFF_CONTROL, 8'h01);
    rd(`IOSC_OFF_CONTROL, 32'h01);
    // unmapped place refuses and leaves the tuning word alone
    wr(8'h10, 8'hff, 4'h1, 2'b10);
    rd(8'h10, 32'h0, 2'b10);
    rd(`IOSC_OFF_TUNING, 32'h80);
    close_out();
  end
endmodule

bind iosc_ctrl iosc_ctrl_properties i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .power_up_timer, .watchdog_en, .fail_safe_monitor, .osc_ctl, .clk_mult,
  .postscale_div);
`default_nettype wire
